// ### dv/ienm_src.sv
// Request source model standing in for the peripherals and pins.
`timescale 1ns/1ps
`default_nettype none
module ienm_src (
  input  wire logic [7:0]     pat,  // Levels, in register bit order.
  output ienm_pkg::ienm_req_t req   // Levels seen by the block.
);
  import ienm_pkg::*;
  // Sources hold plain levels, so the block may sample on any edge.
  assign req = ienm_req_t'(pat);
endmodule : ienm_src
`default_nettype wire

// ### dv/test_interrupt_enable_mask.sv
// Self-checking testbench for the interrupt enable mask block.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_enable_mask;
  import ienm_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  ienm_sfr_t  sfr = '0;
  logic [7:0] pat = 8'h00;
  ienm_req_t  req;
  logic [7:0] rdata_q;
  logic [7:0] mask_q;
  logic       rvalid_q;
  logic [6:0] gated_q;
  int         errors = 0;
  int         n_checks = 0;
  int         cyc = 0;
  always #4 ref_clk = ~ref_clk;
  ienm_src u_src (.pat(pat), .req(req));
  ienm_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr(sfr), .req(req),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .gated_q(gated_q),
    .mask_q(mask_q));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // One strobe cycle; returns at the falling edge after the taking edge.
  task automatic access(input logic [7:0] a, input logic b,
                        input logic [2:0] s, input logic w,
                        input logic [7:0] d);
    @(negedge ref_clk);
    sfr <= '{addr: a, bit_acc: b, bit_sel: s, wr: w, wdata: d, rd: !w};
    @(negedge ref_clk);
    sfr <= '0;
  endtask : access
  task automatic rd_chk(input logic [7:0] a, input logic b,
                        input logic [2:0] s, input logic v,
                        input logic [7:0] d);
    access(a, b, s, 1'b0, 8'h00);
    check({7'h00, rvalid_q}, {7'h00, v});
    check(rdata_q, d);
  endtask : rd_chk
  task automatic t_regs;
    rd_chk(IENM_ADDR, 1'b0, 3'h0, 1'b1, IENM_RESET);
    access(IENM_ADDR, 1'b0, 3'h0, 1'b1, 8'h5A);
    rd_chk(IENM_ADDR, 1'b0, 3'h0, 1'b1, 8'h5A);
    access(8'hA9, 1'b0, 3'h0, 1'b1, 8'hFF);
    rd_chk(8'hA9, 1'b0, 3'h0, 1'b0, 8'h00);
    check(mask_q, 8'h5A);
    access(IENM_ADDR, 1'b0, 3'h0, 1'b1, 8'h00);
    for (int k = 0; k < 8; k++) begin
      rd_chk(IENM_ADDR, 1'b1, 3'(k), 1'b1, 8'h00);
      access(IENM_ADDR, 1'b1, 3'(k), 1'b1, 8'h01);
      rd_chk(IENM_ADDR, 1'b1, 3'(k), 1'b1, 8'h01);
      check(mask_q, 8'((2 << k) - 1));
    end
    access(IENM_ADDR, 1'b1, 3'h3, 1'b1, 8'h00);
    rd_chk(IENM_ADDR, 1'b0, 3'h0, 1'b1, 8'hF7);
    $display("register test done");
  endtask : t_regs
  // Each mask bit alone, with the global enable off and then on.
  task automatic t_gate;
    logic [7:0] pats [4];
    logic [7:0] m;
    logic [6:0] e;
    pats = '{8'hFF, 8'h40, 8'h20, 8'h04};
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 7; b++) begin
        m = 8'(g << 7) | 8'(1 << b);
        access(IENM_ADDR, 1'b0, 3'h0, 1'b1, m);
        for (int i = 0; i < 4; i++) begin
          pat <= pats[i];
          @(negedge ref_clk);
          e = {m[6] & pats[i][7], m[5] & (pats[i][6] | pats[i][5]),
               m[4:0] & pats[i][4:0]} & {7{m[7]}};
          check({1'b0, gated_q}, {1'b0, e});
        end
      end
    end
    $display("gating test done");
  endtask : t_gate
  // A mid-run reset must clear every bit and silence the outputs.
  task automatic t_reset;
    pat <= 8'hFF;
    access(IENM_ADDR, 1'b0, 3'h0, 1'b1, 8'hFF);
    @(negedge ref_clk);
    check({1'b0, gated_q}, 8'h7F);
    rst_n <= 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n <= 1'b1;
    check(mask_q, IENM_RESET);
    check({1'b0, gated_q}, 8'h00);
    @(negedge ref_clk);
    check({1'b0, gated_q}, 8'h00);
    rd_chk(IENM_ADDR, 1'b0, 3'h0, 1'b1, IENM_RESET);
    $display("reset test done");
  endtask : t_reset
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // A hang is cut short well past the roughly 170 cycles the tests need.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_gate();
    t_reset();
    end_of_test();
  end
endmodule : test_interrupt_enable_mask
`default_nettype wire

// ### logic/ienm_pkg.sv
// Package for the interrupt enable mask block: map, fields, carriers.
// Overview of operation
// - Bit 7 globally gates every interrupt source.
// - Bit 6 masks serial peripheral interface requests.
// - Bit 5 masks timer C, either overflow flag.
// - Bit 4 masks the asynchronous serial port.
// - Bit 3 masks timer B overflow flag.
// - Bit 2 masks external interrupt B input.
// - Bit 1 masks timer A overflow flag.
// - Register at 0xA8, bit and byte access.
package ienm_pkg;

  // ****************************************************************
  // Register map and field positions.
  // ****************************************************************
  localparam logic [7:0] IENM_ADDR        = 8'hA8;  // Register address.
  localparam logic [7:0] IENM_RESET       = 8'h00;  // Reset value.
  localparam int         IENM_GLOBAL_BIT  = 7;      // Global enable.
  localparam int         IENM_SPI_BIT     = 6;      // Serial periph mask.
  localparam int         IENM_TMRC_BIT    = 5;      // Timer C mask.
  localparam int         IENM_ASER_BIT    = 4;      // Async serial mask.
  localparam int         IENM_TMRB_BIT    = 3;      // Timer B mask.
  localparam int         IENM_EXTB_BIT    = 2;      // External B mask.
  localparam int         IENM_TMRA_BIT    = 1;      // Timer A mask.
  localparam int         IENM_EXTA_BIT    = 0;      // External A mask.

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  // Raw requests from the sources, in register bit order.
  typedef struct packed {
    logic serial_periph_req;           // Serial peripheral request.
    logic timer_c_low_overflow_flag;   // Timer C low byte overflow.
    logic timer_c_high_overflow_flag;  // Timer C high byte overflow.
    logic async_serial_req;            // Async serial port request.
    logic timer_b_overflow_flag;       // Timer B overflow.
    logic ext_irq_b_input;             // External interrupt B request.
    logic timer_a_overflow_flag;       // Timer A overflow.
    logic ext_irq_a_input;             // External interrupt A request.
  } ienm_req_t;

  // Special-function-register bus access from the core.
  typedef struct packed {
    logic [7:0] addr;     // Byte address, or bit-area address.
    logic       bit_acc;  // High for a single-bit access.
    logic [2:0] bit_sel;  // Bit number for a single-bit access.
    logic       wr;       // Write strobe, one cycle.
    logic [7:0] wdata;    // Byte write data; bit 0 for bit writes.
    logic       rd;       // Read strobe, one cycle.
  } ienm_sfr_t;

endpackage : ienm_pkg

// ### logic/ienm_top.sv
// Interrupt enable mask register with request gating.
`timescale 1ns/1ps
`default_nettype none
module ienm_top (
  input  wire logic                ref_clk,   // System clock, 125 MHz.
  input  wire logic                rst_n,     // Async reset, active low.
  input  wire ienm_pkg::ienm_sfr_t sfr,       // Core register access.
  input  wire ienm_pkg::ienm_req_t req,       // Raw source requests.
  output logic [7:0]               rdata_q,   // Read data, registered.
  output logic                     rvalid_q,  // Read data valid pulse.
  output logic [6:0]               gated_q,   // Forwarded requests.
  output logic [7:0]               mask_q     // Register contents.
);
  import ienm_pkg::*;

  // ****************************************************************
  // Address decode.
  // ****************************************************************
  // The register is bit-addressable; its bit area sits at the same base,
  // so a bit access selects the register when addr matches the base.
  logic hit;  // Access targets this register.
  assign hit = (sfr.addr == IENM_ADDR);

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  // A bit write touches only the selected bit, so software can flip one
  // mask without a read-modify-write race against other bits.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= IENM_RESET;
    end else if (sfr.wr && hit) begin
      if (sfr.bit_acc) begin
        mask_q[sfr.bit_sel] <= sfr.wdata[0];
      end else begin
        mask_q <= sfr.wdata;
      end
    end
  end

  // A byte write replaces the whole register on the next edge.
  a_byte_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sfr.wr && hit && !sfr.bit_acc |=> mask_q == $past(sfr.wdata))
    else $error("Byte write not stored.");

  // A bit write stores write data bit 0 into the selected bit.
  a_bit_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sfr.wr && hit && sfr.bit_acc |=>
      mask_q[$past(sfr.bit_sel)] == $past(sfr.wdata[0]))
    else $error("Bit write not stored.");

  // A bit write must leave every other bit as it was.
  a_bit_others: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sfr.wr && hit && sfr.bit_acc |=>
      ((mask_q ^ $past(mask_q)) & ~(8'h01 << $past(sfr.bit_sel))) == 8'h00)
    else $error("Bit write disturbed other bits.");

  // Without a write strobe to this address the contents hold.
  a_hold_value: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !(sfr.wr && hit) |=> $stable(mask_q))
    else $error("Register changed without write.");

  // Leaving reset, the register and every output start at zero, so
  // no source can slip through before software sets its mask.
  a_reset_clear: assert property (
    @(posedge ref_clk)
    $rose(rst_n) |-> mask_q == IENM_RESET && gated_q == 7'h00 &&
      !rvalid_q && rdata_q == 8'h00)
    else $error("State not cleared by reset.");

  // Read path: byte returns all bits, bit read returns bit in bit 0.
  // Unmapped addresses read zero with no valid pulse.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= sfr.rd && hit;
      if (sfr.rd && hit) begin
        if (sfr.bit_acc) begin
          rdata_q <= {7'h00, mask_q[sfr.bit_sel]};
        end else begin
          rdata_q <= mask_q;
        end
      end else begin
        rdata_q <= 8'h00;  // Quiet bus when this register is not read.
      end
    end
  end

  // A byte read returns the contents held before the strobe edge, so a
  // write in the same cycle shows only on the following read.
  a_read_back: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sfr.rd && hit && !sfr.bit_acc |=> rvalid_q && rdata_q == $past(mask_q))
    else $error("Byte read mismatch.");

  // A bit read returns the selected bit in bit 0, upper bits zero.
  a_bit_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    sfr.rd && hit && sfr.bit_acc |=>
      rvalid_q && rdata_q == {7'h00, $past(mask_q[sfr.bit_sel])})
    else $error("Bit read mismatch.");

  // Anything but a read of this register leaves the read port quiet.
  a_refused_read: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !(sfr.rd && hit) |=> !rvalid_q && rdata_q == 8'h00)
    else $error("Read answered without a hit.");

  // ****************************************************************
  // Request gating.
  // ****************************************************************
  // Gating uses the stored mask, so a write takes effect one cycle after
  // its strobe; output is registered, adding one more cycle of latency.
  // The extra cycle was accepted so that every output leaves a flop and
  // the core never sees a glitch from the combinational gate.
  logic       global_irq_enable;       // Bit 7: gates every source.
  logic       serial_periph_irq_mask;  // Bit 6: serial periph interface.
  logic       timer_c_irq_mask;        // Bit 5: timer C, either byte.
  logic       async_serial_irq_mask;   // Bit 4: async serial port.
  logic       timer_b_irq_mask;        // Bit 3: timer B overflow.
  logic       ext_irq_b_mask;          // Bit 2: external input B.
  logic       timer_a_irq_mask;        // Bit 1: timer A overflow.
  logic       ext_irq_a_mask;          // Bit 0: external input A.
  logic [6:0] gate_d;                  // Next forwarded requests.

  // Named views of the register fields keep the gate readable.
  assign global_irq_enable      = mask_q[IENM_GLOBAL_BIT];
  assign serial_periph_irq_mask = mask_q[IENM_SPI_BIT];
  assign timer_c_irq_mask       = mask_q[IENM_TMRC_BIT];
  assign async_serial_irq_mask  = mask_q[IENM_ASER_BIT];
  assign timer_b_irq_mask       = mask_q[IENM_TMRB_BIT];
  assign ext_irq_b_mask         = mask_q[IENM_EXTB_BIT];
  assign timer_a_irq_mask       = mask_q[IENM_TMRA_BIT];
  assign ext_irq_a_mask         = mask_q[IENM_EXTA_BIT];

  // Each source passes only with its own mask and the global enable set.
  // Timer C has two flags; either of them raises the one request line.
  always_comb begin
    gate_d    = 7'h00;  // Default keeps every bit assigned.
    gate_d[6] = global_irq_enable && serial_periph_irq_mask &&
                req.serial_periph_req;
    gate_d[5] = global_irq_enable && timer_c_irq_mask &&
                (req.timer_c_low_overflow_flag ||
                 req.timer_c_high_overflow_flag);
    gate_d[4] = global_irq_enable && async_serial_irq_mask &&
                req.async_serial_req;
    gate_d[3] = global_irq_enable && timer_b_irq_mask &&
                req.timer_b_overflow_flag;
    gate_d[2] = global_irq_enable && ext_irq_b_mask &&
                req.ext_irq_b_input;
    gate_d[1] = global_irq_enable && timer_a_irq_mask &&
                req.timer_a_overflow_flag;
    gate_d[0] = global_irq_enable && ext_irq_a_mask &&
                req.ext_irq_a_input;
  end

  // Forwarded requests are registered; reset blocks every source.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gated_q <= 7'h00;
    end else begin
      gated_q <= gate_d;
    end
  end

  // With the global enable clear nothing may leave on the next edge.
  a_global_blocks: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !$past(mask_q[IENM_GLOBAL_BIT]) |-> gated_q == 7'h00)
    else $error("Request passed with global enable clear.");

  // Serial peripheral requests follow their mask and the global enable.
  a_spi_mask: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gated_q[6] == $past(mask_q[IENM_GLOBAL_BIT] && mask_q[IENM_SPI_BIT] &&
                        req.serial_periph_req))
    else $error("Serial periph gating wrong.");

  // Timer C forwards when either of its two flags is set.
  a_timer_c_or: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gated_q[5] == $past(mask_q[IENM_GLOBAL_BIT] && mask_q[IENM_TMRC_BIT] &&
                        (req.timer_c_low_overflow_flag ||
                         req.timer_c_high_overflow_flag)))
    else $error("Timer C gating wrong.");

  // The asynchronous serial port follows its mask.
  a_async_mask: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gated_q[4] == $past(mask_q[IENM_GLOBAL_BIT] && mask_q[IENM_ASER_BIT] &&
                        req.async_serial_req))
    else $error("Async serial gating wrong.");

  // Timer B forwards its overflow flag when unmasked.
  a_timer_b_mask: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gated_q[3] == $past(mask_q[IENM_GLOBAL_BIT] && mask_q[IENM_TMRB_BIT] &&
                        req.timer_b_overflow_flag))
    else $error("Timer B gating wrong.");

  // External input B forwards when unmasked.
  a_ext_b_mask: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gated_q[2] == $past(mask_q[IENM_GLOBAL_BIT] && mask_q[IENM_EXTB_BIT] &&
                        req.ext_irq_b_input))
    else $error("External B gating wrong.");

  // Timer A forwards its overflow flag when unmasked.
  a_timer_a_mask: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gated_q[1] == $past(mask_q[IENM_GLOBAL_BIT] && mask_q[IENM_TMRA_BIT] &&
                        req.timer_a_overflow_flag))
    else $error("Timer A gating wrong.");

  // External input A forwards when unmasked.
  a_ext_a_mask: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gated_q[0] == $past(mask_q[IENM_GLOBAL_BIT] && mask_q[IENM_EXTA_BIT] &&
                        req.ext_irq_a_input))
    else $error("External A gating wrong.");

endmodule : ienm_top
`default_nettype wire
